//--- hdl/mpd_pkg.sv
// Constants and types for the multiplexed port data registers
// Operation
// - Other-function mode: read returns stored bit; write stores, pin unaffected.
// - Output mode 01: stored bit driven on pin; read returns stored value.
// - Input modes 10/11: read returns pin level; 10 pull-up on, 11 off.
// - Each pin has pull-up enabled by its port control mode setting.
// - Port B data follows same mode-dependent read/write behaviour.
// - Port C data is 8-bit read/write, bit n maps to pin n.
// - Power-on reset clears port C data to zero.
// - Port D data is 8-bit read/write, pin mapped, cleared at power-on.
// - Data kept across standby, sleep, manual reset; only power-on clears.
// - Port E cleared at power-on; pins default to input with pull-up.
// - Port F bits 6..0 writable and mapped; bit 7 reads zero.
// - Ports F and G default to input with pull-up after power-on.
// - Port G input-only, six pins, read-only, no defined reset value.
// - Port G writes ignored; other-function reads low; mode 01 reserved.
package mpd_pkg;

  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 6;

  // Register addresses on the plain port
  localparam logic [3:0] ADDR_B = 4'h0;
  localparam logic [3:0] ADDR_C = 4'h1;
  localparam logic [3:0] ADDR_D = 4'h2;
  localparam logic [3:0] ADDR_E = 4'h3;
  localparam logic [3:0] ADDR_F = 4'h4;
  localparam logic [3:0] ADDR_G = 4'h5;
  localparam logic [3:0] ADDR_MODE_B = 4'h8;
  localparam logic [3:0] ADDR_MODE_C = 4'h9;
  localparam logic [3:0] ADDR_MODE_D = 4'ha;
  localparam logic [3:0] ADDR_MODE_E = 4'hb;
  localparam logic [3:0] ADDR_MODE_F = 4'hc;
  localparam logic [3:0] ADDR_MODE_G = 4'hd;

  // Writable-bit masks and reset values
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_F = 8'h7f;
  localparam logic [7:0] MASK_G = 8'h3f;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [15:0] MODE_RST_OTHER = 16'h0000;
  localparam logic [15:0] MODE_RST_INPU = 16'haaaa;

  // Per-pin mode encoding
  typedef enum logic [1:0] {
    MPD_MODE_OTHER = 2'b00,
    MPD_MODE_OUT   = 2'b01,
    MPD_MODE_INPU  = 2'b10,
    MPD_MODE_IN    = 2'b11
  } mpd_mode_type;

  // Register access request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } mpd_req_type;

endpackage : mpd_pkg

//--- hdl/mpd_pin_bit.sv
// One port pin: synchroniser, read mux, drive and pull-up decode
`timescale 1ns/1ps
module mpd_pin_bit
  import mpd_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_stored,
  input  wire logic       i_pin,
  input  wire logic       i_low_other,
  output logic            o_read,
  output logic            o_drive,
  output logic            o_pullup,
  output logic            o_out
);

  logic pin_meta;
  logic pin_sync;

  // Pin level is asynchronous to the bus clock
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
    end
  end

  // Read source and pin control by mode
  always_comb
  begin
    o_out = i_stored;
    o_drive = 1'b0;
    o_pullup = 1'b0;
    case (mpd_mode_type'(i_mode))
      MPD_MODE_OTHER: o_read = i_low_other ? 1'b0 : i_stored;
      MPD_MODE_OUT:
      begin
        o_read = i_stored;
        o_drive = 1'b1;
      end
      MPD_MODE_INPU:
      begin
        o_read = pin_sync;
        o_pullup = 1'b1;
      end
      MPD_MODE_IN: o_read = pin_sync;
      default: o_read = 1'b0;
    endcase
  end

endmodule : mpd_pin_bit

//--- hdl/mpd_ports.sv
// Data registers of ports B to G with mode-dependent pin behaviour
`timescale 1ns/1ps
module mpd_ports
  import mpd_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  input  wire logic [47:0] i_pin,
  output logic [47:0]      o_pin,
  output logic [47:0]      o_pin_oe_n,
  output logic [47:0]      o_pullup,
  output logic [47:0]      o_periph_sel
);

  logic        rst_meta;
  logic        rst_sync_n;
  mpd_req_type req;
  logic [7:0]  data [NUM_PORTS];
  logic [15:0] mode [NUM_PORTS];
  logic [47:0] rd_bits;
  logic [47:0] drv_bits;
  logic [47:0] pu_bits;
  logic [47:0] out_bits;
  logic [15:0] next_rdata;
  logic [7:0]  wmask [NUM_PORTS];
  logic        out_live;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  //////////////////////////////////////////////////////////////////////////
  // Reset release; this reset is power-on only, so standby, sleep and
  // manual reset never reach the data registers
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Writable masks per port
  always_comb
  begin
    wmask[0] = MASK_FULL;
    wmask[1] = MASK_FULL;
    wmask[2] = MASK_FULL;
    wmask[3] = MASK_FULL;
    wmask[4] = MASK_F;
    wmask[5] = MASK_G;
  end

  //////////////////////////////////////////////////////////////////////////
  // Data registers of B..F; G's register is never written and stays at DATA_RST
  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
        data[p] <= DATA_RST;
    end
    else if (req.wr && req.addr < 4'(NUM_PORTS - 1))
    begin
      // Upper reserved bits never store
      data[req.addr[2:0]] <= req.wdata[7:0] & wmask[req.addr[2:0]];
    end
  end

  // Mode settings from the pin function controller
  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
        mode[p] <= (p >= 3) ? MODE_RST_INPU : MODE_RST_OTHER;
    end
    else if (req.wr && req.addr >= ADDR_MODE_B && req.addr <= ADDR_MODE_G)
    begin
      mode[3'(req.addr - ADDR_MODE_B)] <= req.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // One pin slice per bit of every port
  for (genvar g = 0; g < 48; g++)
  begin : g_pin
    mpd_pin_bit u_bit (
      .i_mclk      (i_mclk),
      .i_rst_n     (rst_sync_n),
      .i_mode      (mode[g / 8][2 * (g % 8) +: 2]),
      .i_stored    (data[g / 8][g % 8] & (g / 8 != 5)),
      .i_pin       (i_pin[g]), // Raw pin into the synchroniser
      .i_low_other (g / 8 == 5),
      .o_read      (rd_bits[g]),
      .o_drive     (drv_bits[g]),
      .o_pullup    (pu_bits[g]),
      .o_out       (out_bits[g])
    );
  end

  // Read data mux; reserved bits read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (req.addr <= ADDR_G)
      next_rdata = {8'h00,
                    rd_bits[8 * req.addr[2:0] +: 8] & wmask[req.addr[2:0]]};
    else if (req.addr >= ADDR_MODE_B && req.addr <= ADDR_MODE_G)
      next_rdata = mode[3'(req.addr - ADDR_MODE_B)];
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge i_mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      o_rdata <= 16'h0000;
      o_pin <= 48'h0;
      o_pin_oe_n <= {48{1'b1}};
      o_pullup <= 48'h0;
      o_periph_sel <= 48'h0;
      out_live <= 1'b0; // Outputs still hold reset values
    end
    else
    begin
      o_rdata <= req.rd ? next_rdata : 16'h0000;
      o_pin <= out_bits;
      out_live <= 1'b1;
      o_pin_oe_n <= ~(drv_bits & ~{{8{1'b1}}, 40'h0});
      o_pullup <= pu_bits & {MASK_G, MASK_F, {4{MASK_FULL}}};
      for (int b = 0; b < 48; b++)
        o_periph_sel[b] <= (mode[b / 8][2 * (b % 8) +: 2] == MPD_MODE_OTHER);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_out_drive;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[1][1:0] == 2'b01)
      |=> (!o_pin_oe_n[8] && o_pin[8] == $past(data[1][0]));
  endproperty
  a_out_drive: assert property (p_out_drive)
    else $error("output mode not driving");

  property p_no_drive_input;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[2][1] == 1'b1) |=> o_pin_oe_n[16];
  endproperty
  a_no_drive_input: assert property (p_no_drive_input)
    else $error("input mode driven");

  property p_g_never_drives;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    1'b1 |=> (o_pin_oe_n[47:40] == 8'hff);
  endproperty
  a_g_never_drives: assert property (p_g_never_drives)
    else $error("port g driven");

  property p_f_bit7_zero;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_F) |=> (o_rdata[15:7] == 9'h0);
  endproperty
  a_f_bit7_zero: assert property (p_f_bit7_zero)
    else $error("reserved f bit set");

  property p_g_upper_zero;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_G) |=> (o_rdata[15:6] == 10'h0);
  endproperty
  a_g_upper_zero: assert property (p_g_upper_zero)
    else $error("reserved g bits set");

  property p_other_reads_store;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_C && mode[1] == 16'h0000)
      |=> (o_rdata[7:0] == $past(data[1]));
  endproperty
  a_other_reads_store: assert property (p_other_reads_store)
    else $error("other read bad");

  property p_write_stores;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.wr && req.addr == ADDR_D) |=> (data[2] == $past(req.wdata[7:0]));
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("write not stored");

  property p_pullup_mode;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[3][1:0] == 2'b10) |=> o_pullup[24];
  endproperty
  a_pullup_mode: assert property (p_pullup_mode)
    else $error("pull-up missing");

  //////////////////////////////////////////////////////////////////////////
  // Read port, storage and pin control checks; the pin control checks wait for
  // out_live so the reset values of the outputs are not taken as faults
  property p_rd_idle_zero;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    !req.rd
      |=> (o_rdata == 16'h0000);
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data outside read cycle");

  property p_rd_upper_zero;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr <= ADDR_G)
      |=> (o_rdata[15:8] == 8'h00);
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero)
    else $error("data read upper byte set");

  property p_c_write_stores;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.wr && req.addr == ADDR_C)
      |=> (data[1] == $past(req.wdata[7:0]));
  endproperty
  a_c_write_stores: assert property (p_c_write_stores)
    else $error("port c write not stored");

  property p_f_write_masked;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.wr && req.addr == ADDR_F)
      |=> (data[4] == ($past(req.wdata[7:0]) & MASK_F));
  endproperty
  a_f_write_masked: assert property (p_f_write_masked)
    else $error("port f write not masked");

  property p_c_hold;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    !(req.wr && req.addr == ADDR_C)
      |=> $stable(data[1]);
  endproperty
  a_c_hold: assert property (p_c_hold)
    else $error("port c data lost");

  property p_g_no_store;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    1'b1
      |=> (data[5] == DATA_RST);
  endproperty
  a_g_no_store: assert property (p_g_no_store)
    else $error("port g stored a write");

  property p_other_no_drive;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[1][1:0] == 2'b00)
      |=> o_pin_oe_n[8];
  endproperty
  a_other_no_drive: assert property (p_other_no_drive)
    else $error("other function pin driven");

  property p_other_sel;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[0][1:0] == 2'b00)
      |=> o_periph_sel[0];
  endproperty
  a_other_sel: assert property (p_other_sel)
    else $error("peripheral not selected");

  property p_out_sel_off;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[0][1:0] == 2'b01)
      |=> !o_periph_sel[0];
  endproperty
  a_out_sel_off: assert property (p_out_sel_off)
    else $error("peripheral selected in output mode");

  property p_b_out_value;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[0][1:0] == 2'b01)
      |=> (!o_pin_oe_n[0] && o_pin[0] == $past(data[0][0]));
  endproperty
  a_b_out_value: assert property (p_b_out_value)
    else $error("port b output value wrong");

  property p_pullup_off;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[3][1:0] == 2'b11)
      |=> !o_pullup[24];
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up on in mode 11");

  property p_other_no_pullup;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[1][1:0] == 2'b00)
      |=> !o_pullup[8];
  endproperty
  a_other_no_pullup: assert property (p_other_no_pullup)
    else $error("pull-up on in other function");

  property p_e_reads_pin;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_E && mode[3] == 16'hffff)
      |=> (o_rdata[7:0] == $past(i_pin[31:24], 3));
  endproperty
  a_e_reads_pin: assert property (p_e_reads_pin)
    else $error("port e input read wrong");

  property p_g_other_low;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_G && mode[5][1:0] == 2'b00)
      |=> !o_rdata[0];
  endproperty
  a_g_other_low: assert property (p_g_other_low)
    else $error("port g other function not low");

  property p_mode_readback;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_MODE_C)
      |=> (o_rdata == $past(mode[1]));
  endproperty
  a_mode_readback: assert property (p_mode_readback)
    else $error("mode readback wrong");

  property p_unmapped_zero;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == 4'h7)
      |=> (o_rdata == 16'h0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_f_pullup;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (out_live && mode[4][1:0] == 2'b10)
      |=> o_pullup[32];
  endproperty
  a_f_pullup: assert property (p_f_pullup)
    else $error("port f pull-up missing");

  property p_g_pin_read;
    @(posedge i_mclk) disable iff (!rst_sync_n)
    (req.rd && req.addr == ADDR_G && mode[5] == 16'hffff)
      |=> (o_rdata[5:0] == $past(i_pin[45:40], 3));
  endproperty
  a_g_pin_read: assert property (p_g_pin_read)
    else $error("port g input read wrong");

endmodule : mpd_ports

//--- test/mpd_pin_model.sv
// External pin model: resolves device drive, bench drive and pull-up
`timescale 1ns/1ps
module mpd_pin_model
(
  input  wire logic [47:0] i_out,
  input  wire logic [47:0] i_oe_n,
  input  wire logic [47:0] i_pullup,
  input  wire logic [47:0] i_ext_val,
  input  wire logic [47:0] i_ext_en,
  output logic [47:0]      o_level
);
  // Device drive wins; a floating unpulled line shows the inverse value
  always_comb
  begin
    for (int k = 0; k < 48; k++)
    begin
      if (!i_oe_n[k])
        o_level[k] = i_out[k];
      else if (i_ext_en[k])
        o_level[k] = i_ext_val[k];
      else if (i_pullup[k])
        o_level[k] = 1'b1;
      else
        o_level[k] = ~i_ext_val[k];
    end
  end
endmodule : mpd_pin_model

//--- test/tb.sv
// Self-checking bench for the port data registers
`timescale 1ns/1ps
`define CHK(g, e) \
  begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import mpd_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [47:0] pin_lvl, o_pin, o_pin_oe_n, o_pullup, o_periph_sel;
  logic [47:0] ext_val = 48'h0;
  logic [47:0] ext_en = 48'h0;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [7:0]  val, m;

  always #4 i_mclk = ~i_mclk;

  mpd_ports dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(pin_lvl), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
    .o_pullup(o_pullup), .o_periph_sel(o_periph_sel));

  mpd_pin_model pins_u (.i_out(o_pin), .i_oe_n(o_pin_oe_n),
    .i_pullup(o_pullup), .i_ext_val(ext_val), .i_ext_en(ext_en),
    .o_level(pin_lvl));

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask : rd

  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rd(ADDR_C, 16'h0000);
    rd(ADDR_D, 16'h0000);
    rd(ADDR_E, 16'h00ff);
    rd(ADDR_F, 16'h007f);
    rd(ADDR_G, 16'h003f);
    // Ports B..F through other, output and both input modes
    ext_val <= 48'h3c3c_3c3c_3c3c;
    for (int p = 0; p < 5; p++)
    begin
      val = 8'hc3 + 8'(p);
      m = (p == 4) ? MASK_F : MASK_FULL;
      wr(ADDR_MODE_B + 4'(p), 16'h0000);
      wr(ADDR_B + 4'(p), {8'hff, val});
      rd(ADDR_B + 4'(p), {8'h00, val & m});
      `CHK(o_pin_oe_n[8*p+:8] & m, m)
      `CHK(o_periph_sel[8*p+:8] & m, m)
      wr(ADDR_MODE_B + 4'(p), 16'h5555);
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK(o_pin_oe_n[8*p+:8] & m, 8'h00)
      `CHK(o_pin[8*p+:8] & m, val & m)
      rd(ADDR_B + 4'(p), {8'h00, val & m});
      ext_en <= 48'hffff_ffff_ffff;
      wr(ADDR_MODE_B + 4'(p), 16'hffff);
      repeat (4) @(posedge i_mclk);
      rd(ADDR_B + 4'(p), {8'h00, 8'h3c & m});
      `CHK(o_pullup[8*p+:8] & m, 8'h00)
      wr(ADDR_MODE_B + 4'(p), 16'haaaa);
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK(o_pullup[8*p+:8] & m, m)
      `CHK(o_pin_oe_n[8*p+:8] & m, m)
      ext_en <= 48'h0;
    end
    // Port G ignores writes and reads low in other function
    wr(ADDR_G, 16'h00ff);
    wr(ADDR_MODE_G, 16'h0000);
    rd(ADDR_G, 16'h0000);
    ext_en <= 48'hffff_ffff_ffff;
    wr(ADDR_MODE_G, 16'hffff);
    repeat (4) @(posedge i_mclk);
    rd(ADDR_G, 16'h003c);
    // Unmapped place: reads zero, write leaves port C data alone
    wr(4'h7, 16'h0011);
    rd(4'h7, 16'h0000);
    wr(ADDR_MODE_C, 16'h0000);
    rd(ADDR_MODE_C, 16'h0000);
    repeat (20) @(posedge i_mclk);
    rd(ADDR_C, 16'h00c4);
    tally_and_finish();
  end
endmodule : tb
